// ==== core/i2cra_pkg.sv ====
// constants and state type for the serial register access slave
package i2cra_pkg;
    localparam int          SYS_CLK_HZ    = 125_000_000;
    localparam int          SCL_STD_HZ    = 100_000;
    localparam int          SCL_MAX_HZ    = 400_000;
    localparam int          SCL_HALF_CYC  = SYS_CLK_HZ / (2 * SCL_MAX_HZ);
    localparam int          SYNC_STAGES   = 2;
    localparam int          BYTE_W        = 8;
    localparam int          REG_COUNT     = 8;
    localparam int          PTR_W         = 3;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [3:0]  DEV_ADDR_HI   = 4'hb;
    localparam logic [1:0]  DEV_ADDR_LO   = 2'h0;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [2:0]  PTR_RESET     = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RECV,
        ST_RECV_ACK,
        ST_RDATA,
        ST_MACK,
        ST_RACKED
    } i2cra_state_t;
endpackage

// ==== core/i2cra_line_if.sv ====
// line events passed from the pin front end to the protocol core
`timescale 1ns/1ps
interface i2cra_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic addr_bit;

    modport front (
        output scl_rise,
        output scl_fall,
        output start,
        output stop,
        output sda,
        output addr_bit
    );
    modport core (
        input scl_rise,
        input scl_fall,
        input start,
        input stop,
        input sda,
        input addr_bit
    );
endinterface

// ==== core/i2cra_front.sv ====
// pin synchronisers and bus condition detector
`timescale 1ns/1ps
module i2cra_front
    import i2cra_pkg::*;
(
    input  wire logic CLK_SYS,
    input  wire logic RST,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    input  wire logic addr_pin,
    i2cra_line_if.front ln
);
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] addr_sync;
    logic       scl_d;
    logic       sda_d;

    // two flops per pin; 125 MHz oversamples a 400 kHz clock widely
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            scl_sync  <= 2'h3;
            sda_sync  <= 2'h3;
            addr_sync <= 2'h0;
        end else begin
            scl_sync  <= {scl_sync[0], scl_pin};
            sda_sync  <= {sda_sync[0], sda_pin};
            addr_sync <= {addr_sync[0], addr_pin};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign ln.scl_rise = scl_sync[1] & ~scl_d;
    assign ln.scl_fall = ~scl_sync[1] & scl_d;
    assign ln.start    = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    assign ln.stop     = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
    assign ln.sda      = sda_sync[1];
    assign ln.addr_bit = addr_sync[1];
endmodule // i2cra_front

// ==== core/i2cra_slave.sv ====
// two-wire slave giving access to eight byte-wide registers
`timescale 1ns/1ps
module i2cra_slave
    import i2cra_pkg::*;
(
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST,
    input  wire logic                          SCL_IN,
    input  wire logic                          SDA_IN,
    output logic                               SDA_OUT,
    output logic                               SDA_OE,
    input  wire logic                          ADDR_SEL,
    output logic [REG_COUNT-1:0][BYTE_W-1:0]   REG_DATA
);
    i2cra_line_if ln ();

    i2cra_state_t                        state;
    logic [3:0]                          cnt;
    logic [BYTE_W-1:0]                   shift;
    logic [BYTE_W-1:0]                   tx;
    logic                                rw;
    logic                                have_ptr;
    logic [PTR_W-1:0]                    ptr;
    logic [REG_COUNT-1:0][BYTE_W-1:0]    regs;
    logic                                rise_ok;
    logic                                fall_ok;
    logic                                done;
    logic                                addr_hit;
    logic                                ptr_load;
    logic                                wr_en;
    logic                                ptr_inc;

    i2cra_front u_front (
        .CLK_SYS  (CLK_SYS),
        .RST      (RST),
        .scl_pin  (SCL_IN),
        .sda_pin  (SDA_IN),
        .addr_pin (ADDR_SEL),
        .ln       (ln.front)
    );

    always_comb begin
        rise_ok  = ln.scl_rise & ~ln.start & ~ln.stop;
        fall_ok  = ln.scl_fall & ~ln.start & ~ln.stop;
        done     = fall_ok & (cnt == BITS_PER_BYTE);
        addr_hit = shift[7:1] == {DEV_ADDR_HI, ln.addr_bit, DEV_ADDR_LO};
        ptr_load = (state == ST_RECV) & done & ~have_ptr;
        wr_en    = (state == ST_RECV) & done & have_ptr;
        ptr_inc  = wr_en | ((state == ST_RDATA) & done);
    end

    // protocol sequencing
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state    <= ST_IDLE;
            cnt      <= 4'h0;
            shift    <= 8'h00;
            tx       <= 8'h00;
            rw       <= 1'b0;
            have_ptr <= 1'b0;
        end else if (ln.start) begin
            state    <= ST_ADDR;
            cnt      <= 4'h0;
            have_ptr <= 1'b0;
        end else if (ln.stop) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    cnt <= 4'h0;
                end
                ST_ADDR: begin
                    if (rise_ok) begin
                        shift <= {shift[6:0], ln.sda};
                        cnt   <= cnt + 4'h1;
                    end
                    if (done) begin
                        rw    <= shift[0];
                        state <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (fall_ok) begin
                        cnt <= 4'h0;
                        if (rw) begin
                            tx    <= regs[ptr];
                            state <= ST_RDATA;
                        end else begin
                            state <= ST_RECV;
                        end
                    end
                end
                ST_RECV: begin
                    if (rise_ok) begin
                        shift <= {shift[6:0], ln.sda};
                        cnt   <= cnt + 4'h1;
                    end
                    if (done) begin
                        have_ptr <= 1'b1;
                        state    <= ST_RECV_ACK;
                    end
                end
                ST_RECV_ACK: begin
                    if (fall_ok) begin
                        cnt   <= 4'h0;
                        state <= ST_RECV;
                    end
                end
                ST_RDATA: begin
                    if (rise_ok) begin
                        cnt <= cnt + 4'h1;
                    end
                    if (done) begin
                        state <= ST_MACK;
                    end else if (fall_ok) begin
                        tx <= {tx[6:0], 1'b0};
                    end
                end
                ST_MACK: begin
                    if (rise_ok) begin
                        state <= ln.sda ? ST_IDLE : ST_RACKED;
                    end
                end
                ST_RACKED: begin
                    if (fall_ok) begin
                        tx    <= regs[ptr];
                        cnt   <= 4'h0;
                        state <= ST_RDATA;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // data line drive, low only while enabled
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            SDA_OE  <= 1'b0;
            SDA_OUT <= 1'b0;
        end else if (ln.start | ln.stop) begin
            SDA_OE <= 1'b0;
        end else if (state == ST_ADDR && done) begin
            SDA_OE <= addr_hit;
        end else if (state == ST_ADDR_ACK && fall_ok) begin
            SDA_OE <= rw & ~regs[ptr][7];
        end else if (state == ST_RECV && done) begin
            SDA_OE <= 1'b1;
        end else if (state == ST_RECV_ACK && fall_ok) begin
            SDA_OE <= 1'b0;
        end else if (state == ST_RDATA && done) begin
            SDA_OE <= 1'b0;
        end else if (state == ST_RDATA && fall_ok) begin
            SDA_OE <= ~tx[6];
        end else if (state == ST_RACKED && fall_ok) begin
            SDA_OE <= ~regs[ptr][7];
        end
    end

    // register pointer, kept across repeated start
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ptr <= PTR_RESET;
        end else if (ptr_load) begin
            ptr <= shift[PTR_W-1:0];
        end else if (ptr_inc) begin
            ptr <= ptr + 3'h1;
        end
    end

    // register bank, written only by a whole byte
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            regs <= {REG_COUNT{REG_RESET}};
        end else if (wr_en) begin
            regs[ptr] <= shift;
        end
    end

    assign REG_DATA = regs;

    a_addr_ack_hit: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (state == ST_ADDR && done && addr_hit) |=> SDA_OE ##0
        (state == ST_ADDR_ACK))
        else $error("matched address not acknowledged");

    a_addr_miss: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (state == ST_ADDR && done && !addr_hit) |=> !SDA_OE &&
        state == ST_IDLE)
        else $error("foreign address answered");

    a_sel_bit_used: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (state == ST_ADDR && done && shift[3] != ln.addr_bit) |=> !SDA_OE)
        else $error("select pin bit ignored");

    a_ptr_load: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        ptr_load |=> ptr == $past(shift[2:0]))
        else $error("pointer not loaded from first byte");

    a_byte_ack: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (state == ST_RECV && done) |=> SDA_OE throughout
        (state == ST_RECV_ACK)[*1])
        else $error("received byte not acknowledged");

    a_write_store: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        wr_en |=> regs[$past(ptr)] == $past(shift) && ptr == $past(ptr) + 3'h1)
        else $error("write byte not stored or pointer not advanced");

    a_abort_hold: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        !wr_en |=> regs == $past(regs))
        else $error("register changed without a whole byte");

    a_restart_ptr: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        ln.start |=> ptr == $past(ptr) && state == ST_ADDR)
        else $error("pointer lost at repeated start");

    a_read_first: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (state == ST_ADDR_ACK && fall_ok && rw) |=> tx == $past(regs[ptr]) &&
        SDA_OE == !$past(regs[ptr][7]))
        else $error("read byte not presented");

    a_read_inc: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (state == ST_RDATA && done) |=> ptr == $past(ptr) + 3'h1 && !SDA_OE)
        else $error("read pointer step wrong");

    a_nack_release: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (state == ST_MACK && rise_ok && ln.sda) |=> !SDA_OE [*2])
        else $error("line held after master nack");
endmodule // i2cra_slave

// ==== verification/i2cra_master.sv ====
// partner model: two-wire bus master with open-drain data
`timescale 1ns/1ps
module i2cra_master
    import i2cra_pkg::*;
(
    input  wire logic CLK_SYS,
    input  wire logic SDA,
    output logic      SCL,
    output logic      SDA_LOW
);
    int half = 40;
    initial begin
        SCL = 1'b1;
        SDA_LOW = 1'b0;
    end
    task automatic wq();
        repeat (half / 2) @(posedge CLK_SYS);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        SDA_LOW <= 1'b0;
        wq();
        SCL <= 1'b1;
        wq();
        SDA_LOW <= 1'b1;
        wq();
        SCL <= 1'b0;
        wq();
    endtask
    task automatic stop();
        SDA_LOW <= 1'b1;
        wq();
        SCL <= 1'b1;
        wq();
        SDA_LOW <= 1'b0;
        wq();
        wq();
    endtask
    task automatic clk_bit(input logic b, output logic r);
        SDA_LOW <= ~b;
        wq();
        SCL <= 1'b1;
        wq();
        r = SDA;
        wq();
        SCL <= 1'b0;
        wq();
    endtask
    // next byte only after the ack clock has passed
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(~more, r);
    endtask
endmodule // i2cra_master

// ==== verification/tb_i2cra_slave.sv ====
// self-checking bench for the two-wire register access slave
`timescale 1ns/1ps
module tb_i2cra_slave
    import i2cra_pkg::*;
;
    logic                             clk = 1'b0;
    logic                             rst;
    logic                             addr_sel;
    logic                             scl;
    logic                             sda_low;
    logic                             sda_out;
    logic                             sda_oe;
    logic [REG_COUNT-1:0][BYTE_W-1:0] reg_data;
    logic [7:0]                       exp [8] = '{default: 8'h00};
    int                               n_fail = 0;
    int                               checks = 0;
    int                               cycles = 0;
    logic                             ack;
    logic [7:0]                       d;
    wire  logic                       sda;

    assign sda = ~sda_low & (sda_oe ? sda_out : 1'b1);
    always #4 clk = ~clk;

    i2cra_slave i2cra_slave_i (
        .CLK_SYS  (clk),
        .RST      (rst),
        .SCL_IN   (scl),
        .SDA_IN   (sda),
        .SDA_OUT  (sda_out),
        .SDA_OE   (sda_oe),
        .ADDR_SEL (addr_sel),
        .REG_DATA (reg_data)
    );
    i2cra_master i2cra_master_i (
        .CLK_SYS (clk),
        .SDA     (sda),
        .SCL     (scl),
        .SDA_LOW (sda_low)
    );

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] %0t byte %h want %h", $time, got, want);
        end
    endtask
    task automatic chk_bit(input logic got, input logic want);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] %0t bit %b want %b", $time, got, want);
        end
    endtask
    task automatic chk_regs();
        for (int i = 0; i < 8; i++) begin
            chk_byte(reg_data[i], exp[i]);
        end
    endtask
    function automatic logic [7:0] dev(input logic a2, input logic rd);
        return {DEV_ADDR_HI, a2, DEV_ADDR_LO, rd};
    endfunction
    task automatic set_ptr(input logic a2, input logic [7:0] p);
        i2cra_master_i.start();
        i2cra_master_i.send(dev(a2, 1'b0), ack);
        chk_bit(ack, 1'b1);
        i2cra_master_i.send(p, ack);
        chk_bit(ack, 1'b1);
    endtask

    task automatic t_write();
        set_ptr(1'b0, 8'h05);
        i2cra_master_i.send(8'ha7, ack);
        chk_bit(ack, 1'b1);
        i2cra_master_i.stop();
        exp[5] = 8'ha7;
        chk_regs();
        $display("t_write done");
    endtask
    task automatic t_addr_sel();
        addr_sel <= 1'b1;
        repeat (8) @(posedge clk);
        i2cra_master_i.start();
        i2cra_master_i.send(dev(1'b0, 1'b0), ack);
        chk_bit(ack, 1'b0);
        i2cra_master_i.stop();
        set_ptr(1'b1, 8'h02);
        i2cra_master_i.send(8'h3c, ack);
        chk_bit(ack, 1'b1);
        i2cra_master_i.stop();
        exp[2] = 8'h3c;
        chk_regs();
        addr_sel <= 1'b0;
        repeat (8) @(posedge clk);
        $display("t_addr_sel done");
    endtask
    task automatic t_seq_write();
        set_ptr(1'b0, 8'hfe);
        for (int k = 0; k < 10; k++) begin
            i2cra_master_i.send(8'(8'h30 + k), ack);
            chk_bit(ack, 1'b1);
            exp[(6 + k) % 8] = 8'(8'h30 + k);
        end
        i2cra_master_i.stop();
        chk_regs();
        $display("t_seq_write done");
    endtask
    task automatic t_abort();
        logic r;
        set_ptr(1'b0, 8'h03);
        repeat (4) i2cra_master_i.clk_bit(1'b1, r);
        i2cra_master_i.stop();
        set_ptr(1'b0, 8'h03);
        repeat (7) i2cra_master_i.clk_bit(1'b0, r);
        i2cra_master_i.start();
        i2cra_master_i.stop();
        chk_regs();
        $display("t_abort done");
    endtask
    task automatic t_read(input logic [7:0] p, input int h);
        i2cra_master_i.half = h;
        set_ptr(1'b0, p);
        i2cra_master_i.start();
        i2cra_master_i.send(dev(1'b0, 1'b1), ack);
        chk_bit(ack, 1'b1);
        i2cra_master_i.recv(1'b0, d);
        chk_byte(d, exp[p[2:0]]);
        chk_bit(sda_oe, 1'b0);
        chk_bit(sda, 1'b1);
        i2cra_master_i.stop();
        i2cra_master_i.half = 40;
        $display("t_read done");
    endtask
    task automatic t_seq_read();
        set_ptr(1'b0, 8'h05);
        i2cra_master_i.start();
        i2cra_master_i.send(dev(1'b0, 1'b1), ack);
        chk_bit(ack, 1'b1);
        for (int k = 0; k < 8; k++) begin
            i2cra_master_i.recv(k < 7, d);
            chk_byte(d, exp[(5 + k) % 8]);
        end
        chk_bit(sda_oe, 1'b0);
        i2cra_master_i.stop();
        $display("t_seq_read done");
    endtask

    initial begin
        rst = 1'b1;
        addr_sel = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk_regs();
        chk_bit(sda_oe, 1'b0);
        chk_bit(sda_out, 1'b0);
        t_write();
        t_addr_sel();
        t_seq_write();
        t_abort();
        t_read(8'h02, 40);
        t_read(8'h07, 156);
        t_seq_read();
        wrap_up();
    end
endmodule // tb_i2cra_slave
